/* File: common/bram_pkg.sv */
// Shared constants and types of the dual-port memory.
//
// Overview of operation
// - Write stores data and echoes it out.
// - Enabled non-write edge reads addressed data out.
// - Output clear zeroes output; a write on the same edge still stores.
// - Address width follows configured port width.
// - Data-in width equals configured port width.
// - Output changes only on active edges.
// - Clock, enable, write, clear polarity selectable.
// - Ports share 4096 bits; address times width.
// - Top addresses 4095/2047/1023/511/255, low bits first.
// - Shapes 1x4096 up to 16x256 supported.
// - Disabled edge: no write, no change.
// - Each port runs on its own clock.
package bram_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int MEM_BITS = 4096; // Shared cell count
    localparam int IDX_W = 12; // Bit index width
    typedef logic [IDX_W-1:0] idx_t; // Bit index into the array
    localparam int DW_A_DEFAULT = 8; // Port A width default
    localparam int DW_B_DEFAULT = 16; // Port B width default
    localparam int SYNC_WARM = 3; // Cycles before edges count

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4; // Register address width
    localparam logic [3:0] REG_CTRL = 4'h0; // Polarity control, rw
    localparam logic [3:0] REG_INFO = 4'h4; // Port widths, ro
    localparam logic [3:0] REG_DOUT_A = 4'h8; // Port A output, ro
    localparam logic [3:0] REG_DOUT_B = 4'hC; // Port B output, ro

    // ----------------------------------------------------------------
    // Control field layout and reset
    // ----------------------------------------------------------------
    localparam int CTRL_W = 8; // Used control bits
    localparam int INV_W = 4; // Inversion bits per port
    localparam int INV_CLK = 0; // Invert port clock
    localparam int INV_EN = 1; // Invert enable
    localparam int INV_WE = 2; // Invert write strobe
    localparam int INV_CLR = 3; // Invert output clear
    localparam int CTRL_B_POS = 4; // Port B field offset
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00; // All true polarity
    localparam int INFO_B_POS = 8; // Port B width in INFO

    // ----------------------------------------------------------------
    // Bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0; // Access done
    localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address

endpackage : bram_pkg

/* File: core/bram_port_sync.sv */
// Front end of one memory port: pin synchroniser, edge detect, polarity.
`timescale 1ns/1ps
`default_nettype none

module bram_port_sync #(
    parameter int DW = bram_pkg::DW_A_DEFAULT,
    localparam int AW = $clog2(bram_pkg::MEM_BITS / DW)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic port_clk,
    input wire logic port_en,
    input wire logic port_we,
    input wire logic port_clr,
    input wire logic [AW-1:0] port_addr,
    input wire logic [DW-1:0] write_data_in,
    input wire logic [bram_pkg::INV_W-1:0] inv,
    output logic op_valid,
    output logic op_write,
    output logic op_clear,
    output logic [AW-1:0] op_addr,
    output logic [DW-1:0] op_data
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] c1;        // Controls, first stage {clr,we,en,clk}
        logic [3:0] c2;        // Controls, second stage
        logic [3:0] c3;        // Controls, one cycle older
        logic [AW-1:0] a1;     // Address stages
        logic [AW-1:0] a2;
        logic [AW-1:0] a3;
        logic [DW-1:0] d1;     // Data stages
        logic [DW-1:0] d2;
        logic [DW-1:0] d3;
        logic [1:0] warm;      // Settling counter after reset
        logic valid;           // One-cycle operation strobe
        logic write;
        logic clear;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } sync_t;

    sync_t q;                  // Registered state
    sync_t d;                  // Next state
    logic act_now;             // Port clock at its active level
    logic act_old;             // Same, one cycle earlier

    // Polarity applied after the second stage only
    assign act_now = q.c2[bram_pkg::INV_CLK] ^ inv[bram_pkg::INV_CLK];
    assign act_old = q.c3[bram_pkg::INV_CLK] ^ inv[bram_pkg::INV_CLK];

    // Next-state logic
    always_comb begin
        d = q;
        d.c1 = {port_clr, port_we, port_en, port_clk};
        d.c2 = q.c1;
        d.c3 = q.c2;
        d.a1 = port_addr;
        d.a2 = q.a1;
        d.a3 = q.a2;
        d.d1 = write_data_in;
        d.d2 = q.d1;
        d.d3 = q.d2;
        if (q.warm != 2'(bram_pkg::SYNC_WARM)) begin
            d.warm = q.warm + 2'h1;
        end
        // Stage three still holds the pre-edge (setup) control values
        d.valid = act_now && !act_old && (q.warm == 2'(bram_pkg::SYNC_WARM))
            && (q.c3[bram_pkg::INV_EN] ^ inv[bram_pkg::INV_EN]);
        d.write = q.c3[bram_pkg::INV_WE] ^ inv[bram_pkg::INV_WE];
        d.clear = q.c3[bram_pkg::INV_CLR] ^ inv[bram_pkg::INV_CLR];
        d.addr = q.a3;
        d.data = q.d3;
    end

    // State register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign op_valid = q.valid;
    assign op_write = q.write;
    assign op_clear = q.clear;
    assign op_addr = q.addr;
    assign op_data = q.data;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_single_strobe: assert property (q.valid |=> !q.valid)
        else $error("operation strobe lasted more than one cycle");
    chk_edge_cause: assert property ($rose(act_now) && q.warm == 2'(bram_pkg::SYNC_WARM)
        && !(q.c3[bram_pkg::INV_EN] ^ inv[bram_pkg::INV_EN]) |=> !q.valid)
        else $error("strobe raised while enable inactive");

endmodule : bram_port_sync

`default_nettype wire

/* File: core/bram_dual.sv */
// Dual-port 4096-bit memory with per-port widths, polarity control and AXI4-Lite view.
`timescale 1ns/1ps
`default_nettype none

module bram_dual #(
    parameter int DW_A = bram_pkg::DW_A_DEFAULT,
    parameter int DW_B = bram_pkg::DW_B_DEFAULT,
    localparam int AW_A = $clog2(bram_pkg::MEM_BITS / DW_A),
    localparam int AW_B = $clog2(bram_pkg::MEM_BITS / DW_B)
) (
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [bram_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [bram_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Memory port A
    input wire logic clk_a,
    input wire logic en_a,
    input wire logic we_a,
    input wire logic clr_a,
    input wire logic [AW_A-1:0] addr_a,
    input wire logic [DW_A-1:0] write_data_in_a,
    output logic [DW_A-1:0] dout_a,
    // Memory port B
    input wire logic clk_b,
    input wire logic en_b,
    input wire logic we_b,
    input wire logic clr_b,
    input wire logic [AW_B-1:0] addr_b,
    input wire logic [DW_B-1:0] write_data_in_b,
    output logic [DW_B-1:0] dout_b
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [bram_pkg::MEM_BITS-1:0] mem;      // Shared bit array
        logic [DW_A-1:0] dout_a;                 // Port A output register
        logic [DW_B-1:0] dout_b;                 // Port B output register
        logic [bram_pkg::CTRL_W-1:0] ctrl;       // Polarity selections
        logic aw_have;                           // Write address held
        logic [bram_pkg::ADDR_W-1:0] aw_addr;
        logic w_have;                            // Write data held
        logic [bram_pkg::CTRL_W-1:0] w_data;
        logic w_lane0;                           // Low byte lane strobe
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } core_t;

    core_t q; // Registered state
    core_t d; // Next state

    logic va, wa, ca; // Port A strobe, write, clear
    logic vb, wb, cb_clr; // Port B strobe, write, clear
    logic [AW_A-1:0] pa; // Port A captured address
    logic [AW_B-1:0] pb; // Port B captured address
    logic [DW_A-1:0] da; // Port A captured data
    logic [DW_B-1:0] db; // Port B captured data
    bram_pkg::idx_t idx_a; // First bit touched by port A
    bram_pkg::idx_t idx_b; // First bit touched by port B

    // ----------------------------------------------------------------
    // Port front ends
    // ----------------------------------------------------------------
    bram_port_sync #(.DW(DW_A)) u_port_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .port_clk(clk_a),
        .port_en(en_a),
        .port_we(we_a),
        .port_clr(clr_a),
        .port_addr(addr_a),
        .write_data_in(write_data_in_a),
        .inv(q.ctrl[bram_pkg::INV_W-1:0]),
        .op_valid(va),
        .op_write(wa),
        .op_clear(ca),
        .op_addr(pa),
        .op_data(da)
    );

    bram_port_sync #(.DW(DW_B)) u_port_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .port_clk(clk_b),
        .port_en(en_b),
        .port_we(we_b),
        .port_clr(clr_b),
        .port_addr(addr_b),
        .write_data_in(write_data_in_b),
        .inv(q.ctrl[bram_pkg::CTRL_B_POS +: bram_pkg::INV_W]),
        .op_valid(vb),
        .op_write(wb),
        .op_clear(cb_clr),
        .op_addr(pb),
        .op_data(db)
    );

    // Address times width; low addresses land on low bits
    assign idx_a = bram_pkg::idx_t'(int'(pa) * DW_A);
    assign idx_b = bram_pkg::idx_t'(int'(pb) * DW_B);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        // Write address and data are taken independently, either order
        if (awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.w_data = wdata[bram_pkg::CTRL_W-1:0];
            d.w_lane0 = wstrb[0];
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        // Both halves present: commit and answer
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = bram_pkg::RESP_OKAY;
            case (q.aw_addr)
                bram_pkg::REG_CTRL: begin
                    // Polarity may change a port's detected edge; change it idle
                    if (q.w_lane0) begin
                        d.ctrl = q.w_data;
                    end
                end
                bram_pkg::REG_INFO, bram_pkg::REG_DOUT_A, bram_pkg::REG_DOUT_B: begin
                    // Read-only: write ignored
                    d.bresp = bram_pkg::RESP_OKAY;
                end
                default: begin
                    d.bresp = bram_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Holding one request each keeps ready honest without buffering
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;

        // Read channel
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = bram_pkg::RESP_OKAY;
            case (araddr)
                bram_pkg::REG_CTRL: begin
                    d.rdata = 32'(q.ctrl);
                end
                bram_pkg::REG_INFO: begin
                    d.rdata = 32'(DW_A) | (32'(DW_B) << bram_pkg::INFO_B_POS);
                end
                bram_pkg::REG_DOUT_A: begin
                    d.rdata = 32'(q.dout_a);
                end
                bram_pkg::REG_DOUT_B: begin
                    d.rdata = 32'(q.dout_b);
                end
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = bram_pkg::RESP_SLVERR;
                end
            endcase
        end
        d.arready = !d.rvalid;

        // Port A; clear still lets the write land in the array
        if (va) begin
            if (wa) begin
                d.mem[idx_a +: DW_A] = da;
            end
            if (ca) begin
                d.dout_a = '0;
            end else if (wa) begin
                d.dout_a = da;
            end else begin
                d.dout_a = q.mem[idx_a +: DW_A];
            end
        end
        // Port B; on overlapping bits B lands last, so B's write data wins
        if (vb) begin
            if (wb) begin
                d.mem[idx_b +: DW_B] = db;
            end
            if (cb_clr) begin
                d.dout_b = '0;
            end else if (wb) begin
                d.dout_b = db;
            end else begin
                d.dout_b = q.mem[idx_b +: DW_B];
            end
        end
    end

    // State register; the array itself has no reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.mem <= q.mem;
            q.ctrl <= bram_pkg::CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign dout_a = q.dout_a;
    assign dout_b = q.dout_b;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    bram_pkg::idx_t idx_a_h; // Port A index one cycle back
    logic [DW_A-1:0] slice_a; // Array bits at current A index
    logic [DW_A-1:0] stored_a; // Array bits at previous A index

    always_ff @(posedge aclk) begin
        idx_a_h <= idx_a;
    end
    assign slice_a = q.mem[idx_a +: DW_A];
    assign stored_a = q.mem[idx_a_h +: DW_A];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_held;
        q.aw_have && q.w_have && !q.bvalid;
    endsequence
    sequence s_write_answered;
        q.bvalid && !q.aw_have && !q.w_have;
    endsequence

    chk_write_echo: assert property (va && wa && !ca |=> q.dout_a == $past(da))
        else $error("port A output did not echo write data");
    chk_write_store: assert property (va && wa && !(vb && wb) |=> stored_a == $past(da))
        else $error("port A write data not stored at address");
    chk_read_data: assert property (va && !wa && !ca |=> q.dout_a == $past(slice_a))
        else $error("port A read returned wrong bits");
    chk_clear_zero: assert property (vb && cb_clr |=> q.dout_b == '0)
        else $error("port B output not cleared");
    chk_clear_keeps: assert property (va && ca && !wa && !(vb && wb) |=> $stable(q.mem))
        else $error("clear without write altered the array");
    chk_hold_idle: assert property (!va |=> $stable(q.dout_a))
        else $error("port A output moved without an active edge");
    chk_b_hold: assert property (!vb [*2] |=> $stable(q.dout_b))
        else $error("port B output moved without an active edge");
    chk_bus_answer: assert property (s_write_held |=> s_write_answered)
        else $error("register write not answered in one cycle");

endmodule : bram_dual

`default_nettype wire

/* File: verif/bram_user_model.sv */
// Fabric logic model driving one memory port.
`timescale 1ns/1ps
`default_nettype none

module bram_user_model #(
    parameter int DW = 8,
    parameter int AW = 9
) (
    input wire logic aclk,
    input wire logic go,
    input wire logic g_en,
    input wire logic g_we,
    input wire logic g_clr,
    input wire logic [AW-1:0] g_addr,
    input wire logic [DW-1:0] g_data,
    output logic done,
    output logic pclk,
    output logic en,
    output logic we,
    output logic clr,
    output logic [AW-1:0] addr,
    output logic [DW-1:0] data
);
    // ------------------------------------------------------------
    // One access: pins, clock pulse, hold
    // ------------------------------------------------------------
    initial begin
        {done, pclk, en, we, clr} = 5'h00;
        addr = '0;
        data = '0;
        forever begin
            @(posedge aclk);
            if (go) begin
                en <= g_en;
                we <= g_we;
                clr <= g_clr;
                addr <= g_addr;
                data <= g_data;
                // Setup before the port edge
                repeat (3) @(posedge aclk);
                pclk <= 1'h1;
                repeat (4) @(posedge aclk);
                // Falling edge is active when inverted
                pclk <= 1'h0;
                repeat (6) @(posedge aclk);
                // Scramble pins so stale values fail
                en <= 1'h0;
                we <= 1'h0;
                clr <= 1'h0;
                addr <= ~addr;
                data <= ~data;
                done <= 1'h1;
                @(posedge aclk);
                done <= 1'h0;
            end
        end
    end
endmodule : bram_user_model

`default_nettype wire

/* File: verif/test_dual_port_block_ram_port.sv */
// Self-checking bench for the dual-port memory.
`timescale 1ns/1ps
`default_nettype none

module test_dual_port_block_ram_port;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk, aresetn;
    logic [bram_pkg::ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic go_a, ge_a, gw_a, gc_a, done_a, clk_a, en_a, we_a, clr_a;
    logic go_b, ge_b, gw_b, gc_b, done_b, clk_b, en_b, we_b, clr_b;
    logic [8:0] ga_a, addr_a;
    logic [7:0] gd_a, wd_a, dout_a, ga_b, addr_b;
    logic [15:0] gd_b, wd_b, dout_b;
    int error_cnt, comparisons, cycles;

    bram_dual u_bram_dual (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .clk_a(clk_a), .en_a(en_a),
        .we_a(we_a), .clr_a(clr_a), .addr_a(addr_a), .write_data_in_a(wd_a),
        .dout_a(dout_a), .clk_b(clk_b), .en_b(en_b), .we_b(we_b), .clr_b(clr_b),
        .addr_b(addr_b), .write_data_in_b(wd_b), .dout_b(dout_b));

    bram_user_model #(.DW(8), .AW(9)) u_bram_user_model_a (
        .aclk(aclk), .go(go_a), .g_en(ge_a), .g_we(gw_a), .g_clr(gc_a), .g_addr(ga_a),
        .g_data(gd_a), .done(done_a), .pclk(clk_a), .en(en_a), .we(we_a), .clr(clr_a),
        .addr(addr_a), .data(wd_a));

    bram_user_model #(.DW(16), .AW(8)) u_bram_user_model_b (
        .aclk(aclk), .go(go_b), .g_en(ge_b), .g_we(gw_b), .g_clr(gc_b), .g_addr(ga_b),
        .g_data(gd_b), .done(done_b), .pclk(clk_b), .en(en_b), .we(we_b), .clr(clr_b),
        .addr(addr_b), .data(wd_b));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end

    // Ceiling well above the test length
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Comparison and closing
    // ------------------------------------------------------------
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        check_val(what, 32'(exp), 32'(got));
    endtask : check_resp

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Register bus master
    // ------------------------------------------------------------
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        bit got;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'h1;
        bready <= 1'h1;
        got = 0;
        while (!got) begin
            @(posedge aclk);
            // Each channel released at its own handshake
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                bready <= 1'h0;
                got = 1;
                check_resp("write response", er, bresp);
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit got;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        got = 0;
        while (!got) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                rready <= 1'h0;
                got = 1;
                check_resp("read response", er, rresp);
                check_val("read data", ed, rdata);
            end
        end
    endtask : axi_read

    // ------------------------------------------------------------
    // Memory port access through the two fabric models
    // ------------------------------------------------------------
    task automatic run_ports(input bit use_a, input bit use_b);
        bit fin;
        @(posedge aclk);
        go_a <= use_a;
        go_b <= use_b;
        fin = 0;
        while (!fin) begin
            @(posedge aclk);
            if (done_a) go_a <= 1'h0;
            if (done_b) go_b <= 1'h0;
            fin = (done_a || !use_a) && (done_b || !use_b);
        end
    endtask : run_ports

    task automatic set_a(input logic e, w, c, input logic [8:0] ad, input logic [7:0] d);
        {ge_a, gw_a, gc_a} <= {e, w, c};
        ga_a <= ad;
        gd_a <= d;
    endtask : set_a

    task automatic set_b(input logic e, w, c, input logic [7:0] ad, input logic [15:0] d);
        {ge_b, gw_b, gc_b} <= {e, w, c};
        ga_b <= ad;
        gd_b <= d;
    endtask : set_b

    task automatic a_acc(input logic e, w, c, input logic [8:0] ad, input logic [7:0] d,
                         input logic [31:0] exp);
        set_a(e, w, c, ad, d);
        run_ports(1, 0);
        check_val("dout_a", exp, 32'(dout_a));
    endtask : a_acc

    task automatic b_acc(input logic e, w, c, input logic [7:0] ad, input logic [15:0] d,
                         input logic [31:0] exp);
        set_b(e, w, c, ad, d);
        run_ports(0, 1);
        check_val("dout_b", exp, 32'(dout_b));
    endtask : b_acc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs();
        check_val("dout_a after reset", 32'h0, 32'(dout_a));
        check_val("dout_b after reset", 32'h0, 32'(dout_b));
        axi_read(bram_pkg::REG_CTRL, 32'h00000000, bram_pkg::RESP_OKAY);
        axi_read(bram_pkg::REG_INFO, 32'h00001008, bram_pkg::RESP_OKAY);
        axi_write(bram_pkg::REG_INFO, 32'hFFFFFFFF, 4'hF, bram_pkg::RESP_OKAY);
        axi_read(bram_pkg::REG_INFO, 32'h00001008, bram_pkg::RESP_OKAY);
        axi_write(4'h2, 32'h00000001, 4'hF, bram_pkg::RESP_SLVERR);
        axi_read(4'h2, 32'h00000000, bram_pkg::RESP_SLVERR);
        $display("test reset_regs done");
    endtask : t_reset_regs

    task automatic t_mapping();
        a_acc(1, 1, 0, 9'h004, 8'h3C, 32'h3C);
        a_acc(1, 1, 0, 9'h005, 8'hA5, 32'hA5);
        b_acc(1, 0, 0, 8'h02, 16'h0000, 32'hA53C);
        b_acc(1, 1, 0, 8'hFF, 16'h1234, 32'h1234);
        a_acc(1, 0, 0, 9'h1FF, 8'h00, 32'h12);
        a_acc(1, 0, 0, 9'h1FE, 8'h00, 32'h34);
        axi_read(bram_pkg::REG_DOUT_A, 32'h34, bram_pkg::RESP_OKAY);
        axi_read(bram_pkg::REG_DOUT_B, 32'h1234, bram_pkg::RESP_OKAY);
        $display("test mapping done");
    endtask : t_mapping

    task automatic t_enable();
        a_acc(0, 1, 0, 9'h004, 8'hFF, 32'h34);
        a_acc(0, 0, 1, 9'h004, 8'h00, 32'h34);
        a_acc(1, 0, 0, 9'h004, 8'h00, 32'h3C);
        $display("test enable done");
    endtask : t_enable

    task automatic t_clear();
        a_acc(1, 0, 1, 9'h004, 8'h00, 32'h00);
        a_acc(1, 0, 0, 9'h004, 8'h00, 32'h3C);
        // Clear with write on A while B writes elsewhere at the same time
        set_a(1, 1, 1, 9'h007, 8'h5A);
        set_b(1, 1, 0, 8'h0A, 16'hBEEF);
        run_ports(1, 1);
        check_val("dout_a", 32'h00, 32'(dout_a));
        check_val("dout_b", 32'hBEEF, 32'(dout_b));
        a_acc(1, 0, 0, 9'h007, 8'h00, 32'h5A);
        a_acc(1, 0, 0, 9'h014, 8'h00, 32'hEF);
        a_acc(1, 0, 0, 9'h015, 8'h00, 32'hBE);
        $display("test clear done");
    endtask : t_clear

    task automatic t_polarity();
        // Port pins are idle and disabled while the inversion changes
        axi_write(bram_pkg::REG_CTRL, 32'h0000001E, 4'h1, bram_pkg::RESP_OKAY);
        axi_read(bram_pkg::REG_CTRL, 32'h0000001E, bram_pkg::RESP_OKAY);
        a_acc(0, 0, 1, 9'h020, 8'h77, 32'h77);
        a_acc(0, 1, 0, 9'h020, 8'h00, 32'h00);
        b_acc(1, 0, 0, 8'h0A, 16'h0000, 32'hBEEF);
        axi_write(bram_pkg::REG_CTRL, 32'h00000000, 4'h0, bram_pkg::RESP_OKAY);
        axi_read(bram_pkg::REG_CTRL, 32'h0000001E, bram_pkg::RESP_OKAY);
        axi_write(bram_pkg::REG_CTRL, 32'h00000000, 4'h1, bram_pkg::RESP_OKAY);
        a_acc(1, 0, 0, 9'h020, 8'h00, 32'h77);
        $display("test polarity done");
    endtask : t_polarity

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        aresetn = 1'h0;
        {awaddr, araddr, wstrb, wdata} = 44'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {go_a, ge_a, gw_a, gc_a, go_b, ge_b, gw_b, gc_b} = 8'h00;
        {ga_a, gd_a, ga_b, gd_b} = 41'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        // Front ends ignore edges just after release
        repeat (8) @(posedge aclk);
        t_reset_regs();
        t_mapping();
        t_enable();
        t_clear();
        t_polarity();
        report_and_stop();
    end
endmodule : test_dual_port_block_ram_port

`default_nettype wire
